// *** clk_src_pkg.sv ***
// constants and types for the cpu clock source selector
// assumes one 40 MHz system clock; oscillator clocks arrive as raw pins
package clk_src_pkg;

  // system clock figures
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int SYS_CLK_PERIOD_NS = 25;

  // crystal warm-up: oscillation cycles masked after start
  localparam int XTAL_WARMUP_CYCLES = 32768;
  localparam int WARMUP_CNT_W = 16;

  // control register layout
  localparam int CTRL_W = 8;
  localparam int BIT_CPU_SLOW = 7;
  localparam int BIT_EXT_SEL = 5;
  localparam int BIT_WARMUP = 3;
  localparam int BIT_XTAL_ON = 1;
  localparam int BIT_RC_ON = 0;

  // reset values of the control bits
  localparam logic RST_CPU_SLOW = 1'h0;
  localparam logic RST_EXT_SEL = 1'h0;
  localparam logic RST_WARMUP = 1'h1;
  localparam logic RST_XTAL_ON = 1'h0;
  localparam logic RST_RC_ON = 1'h1;

  // cpu clock divider codes: nodiv, div2, div4, div8, div16
  localparam int DIV_CODE_W = 3;
  localparam logic [2:0] DIV_CODE_MAX = 3'h4;
  localparam int DIV_CNT_W = 4;

  // synchronised pin inputs, index into the sync vector
  localparam int NUM_PINS = 5;
  localparam int PIN_RC = 0;
  localparam int PIN_XTAL = 1;
  localparam int PIN_EXT = 2;
  localparam int PIN_HP32K = 3;
  localparam int PIN_RSTN = 4;

  // clock sources for the cpu and the prescalers
  typedef enum logic [2:0] {SRC_NONE, SRC_RC, SRC_XTAL, SRC_EXT, SRC_HP} clk_src_t;

  // switch sequencer states
  typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} sw_state_t;

  // software-visible control bits
  typedef struct packed {
    logic cpu_slow_clock_select;
    logic ext_clock_select;
    logic crystal_warmup_flag;
    logic crystal_osc_on;
    logic rc_osc_on;
  } sys_clock_ctrl_t;

  // routing of the three clock targets
  typedef struct packed {
    clk_src_t cpu;
    clk_src_t high_pre;
    clk_src_t low_pre;
  } clk_route_t;

endpackage

// *** system_clock_source_select.sv ***
// cpu clock source selector with crystal warm-up and target routing
// assumes oscillator clocks and the reset pin are asynchronous pins;
// clocks leave the block as one-cycle enable pulses on the system clock
//
// What this block does
// - crystal output masked for 32768 cycles
// - resets and sleep clear enable, set flag
// - enable starts crystal, flag clears after 32768
// - clearing enable stops the crystal
// - sleep stops the crystal
// - external pin clock divided by two
// - external select switches system to external clock
// - crystal unavailable while external clock selected
// - resets select rc; sleep exit selects rc unless external select is set
// - speed bit picks fastest or 32 kHz source
// - cpu clock source changes are glitch free
// - routing for off, crystal-only and rc-only modes
// - routing for rc plus crystal and external
// - rc or external cpu clock divided 1..16
// - control bits at 7, 5, 3, 1, 0
`timescale 1ns/10ps

module system_clock_source_select
  import clk_src_pkg::*;
#(
  parameter int WARMUP_CYCLES = XTAL_WARMUP_CYCLES
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sleep_mode,
  input wire logic external_reset_pin_n,
  input wire logic rc_clk_pin,
  input wire logic xtal_clk_pin,
  input wire logic ext_clk_pin,
  input wire logic hp_tap_32k,
  input wire logic ctl_wr,
  input wire logic [CTRL_W-1:0] ctl_wdata,
  input wire logic [DIV_CODE_W-1:0] cpu_div_code,
  output logic [CTRL_W-1:0] ctl_rdata,
  output logic rc_osc_run,
  output logic xtal_osc_run,
  output logic cpu_clk_en,
  output logic high_pre_clk_en,
  output logic low_pre_clk_en,
  output logic slow_32k_clock
);

  localparam logic [WARMUP_CNT_W-1:0] WARMUP_LAST = WARMUP_CNT_W'(WARMUP_CYCLES - 1);

  sys_clock_ctrl_t ctrl_q;
  clk_route_t route;
  clk_src_t cur_q;
  sw_state_t sw_q;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] prev_q;
  logic [NUM_PINS-1:0] rise;
  logic [WARMUP_CNT_W-1:0] warm_cnt_q;
  logic ext_half_q;
  logic [DIV_CNT_W-1:0] div_cnt_q;
  logic [DIV_CNT_W-1:0] div_last;
  logic cold_rst, sleep_rst;
  logic rc_p, xtal_raw_p, xtal_p, ext_p, hp_p;
  logic cur_p, tgt_p, div_p;
  logic cpu_d, high_d, low_d;
  logic xtal_start, warm_done;

  // two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge clock)
  begin
    sync1_q <= {external_reset_pin_n, hp_tap_32k, ext_clk_pin, xtal_clk_pin, rc_clk_pin};
    sync2_q <= sync1_q;
    prev_q <= sync2_q;
  end

  assign rise = sync2_q & ~prev_q;

  // pin reset acts on its low level, sleep on top of the cold resets
  assign cold_rst = srst | ~sync2_q[PIN_RSTN];
  assign sleep_rst = cold_rst | sleep_mode;

  // raw source pulses; rc and crystal gated by the oscillator run enables, the 32 kHz tap ungated
  assign rc_p = rise[PIN_RC] & rc_osc_run;
  assign xtal_raw_p = rise[PIN_XTAL] & xtal_osc_run;
  assign hp_p = rise[PIN_HP32K];

  always_ff @(posedge clock)
  begin
    if (cold_rst || !ctrl_q.ext_clock_select)
      ext_half_q <= 1'h0;
    else if (rise[PIN_EXT])
      ext_half_q <= ~ext_half_q;
  end

  assign ext_p = rise[PIN_EXT] & ext_half_q & ctrl_q.ext_clock_select;

  // enable bits reset on power-on, pin and sleep
  // clear enable, force rc
  always_ff @(posedge clock)
  begin
    if (sleep_rst)
    begin
      ctrl_q.cpu_slow_clock_select <= RST_CPU_SLOW;
      ctrl_q.crystal_osc_on <= RST_XTAL_ON;
      ctrl_q.rc_osc_on <= RST_RC_ON;
    end
    else if (ctl_wr)
    begin
      ctrl_q.cpu_slow_clock_select <= ctl_wdata[BIT_CPU_SLOW];
      ctrl_q.crystal_osc_on <= ctl_wdata[BIT_XTAL_ON];
      ctrl_q.rc_osc_on <= ctl_wdata[BIT_RC_ON];
    end
  end

  // external select survives sleep, only cold resets clear it
  // external clock select bit
  always_ff @(posedge clock)
  begin
    if (cold_rst)
      ctrl_q.ext_clock_select <= RST_EXT_SEL;
    else if (ctl_wr)
      ctrl_q.ext_clock_select <= ctl_wdata[BIT_EXT_SEL];
  end

  // oscillator run lines
  // crystal stop conditions
  assign xtal_osc_run = ctrl_q.crystal_osc_on & ~ctrl_q.ext_clock_select & ~sleep_mode;
  assign rc_osc_run = ctrl_q.rc_osc_on & ~sleep_mode;

  // a fresh start of the crystal restarts the warm-up
  assign xtal_start = ctl_wr & ctl_wdata[BIT_XTAL_ON] & ~ctrl_q.crystal_osc_on & ~sleep_rst;
  assign warm_done = xtal_raw_p & (warm_cnt_q == WARMUP_LAST);

  always_ff @(posedge clock)
  begin
    if (sleep_rst || xtal_start || !xtal_osc_run)
      warm_cnt_q <= '0;
    else if (xtal_raw_p && ctrl_q.crystal_warmup_flag)
      warm_cnt_q <= warm_cnt_q + WARMUP_CNT_W'(1);
  end

  // set wins over the end of count
  // flag set and clear
  always_ff @(posedge clock)
  begin
    if (sleep_rst || xtal_start)
      ctrl_q.crystal_warmup_flag <= RST_WARMUP;
    else if (warm_done)
      ctrl_q.crystal_warmup_flag <= 1'h0;
  end

  assign xtal_p = xtal_raw_p & ~ctrl_q.crystal_warmup_flag;

  // read-back image; unused bits read zero
  // control bit layout
  always_comb
  begin
    ctl_rdata = '0;
    ctl_rdata[BIT_CPU_SLOW] = ctrl_q.cpu_slow_clock_select;
    ctl_rdata[BIT_EXT_SEL] = ctrl_q.ext_clock_select;
    ctl_rdata[BIT_WARMUP] = ctrl_q.crystal_warmup_flag;
    ctl_rdata[BIT_XTAL_ON] = ctrl_q.crystal_osc_on;
    ctl_rdata[BIT_RC_ON] = ctrl_q.rc_osc_on;
  end

  // clocking mode table
  // route targets
  always_comb
  begin
    route.cpu = SRC_NONE;
    route.high_pre = SRC_NONE;
    route.low_pre = SRC_NONE;
    if (ctrl_q.ext_clock_select)
    begin
      route.cpu = ctrl_q.cpu_slow_clock_select ? SRC_HP : SRC_EXT;
      route.high_pre = SRC_EXT;
      route.low_pre = SRC_HP;
    end
    else if (ctrl_q.rc_osc_on && ctrl_q.crystal_osc_on)
    begin
      route.cpu = ctrl_q.cpu_slow_clock_select ? SRC_XTAL : SRC_RC;
      route.high_pre = SRC_RC;
      route.low_pre = SRC_XTAL;
    end
    else if (ctrl_q.rc_osc_on)
    begin
      route.cpu = ctrl_q.cpu_slow_clock_select ? SRC_HP : SRC_RC;
      route.high_pre = SRC_RC;
      route.low_pre = SRC_HP;
    end
    else if (ctrl_q.crystal_osc_on)
    begin
      route.cpu = SRC_XTAL;
      route.low_pre = SRC_XTAL;
    end
  end

  // pulse of a given source
  function automatic logic src_pulse(input clk_src_t s, input logic r, input logic x,
                                     input logic e, input logic h);
    logic p;
    p = 1'h0;
    case (s)
      SRC_RC: p = r;
      SRC_XTAL: p = x;
      SRC_EXT: p = e;
      SRC_HP: p = h;
      default: p = 1'h0;
    endcase
    return p;
  endfunction

  assign cur_p = src_pulse(cur_q, rc_p, xtal_p, ext_p, hp_p);
  assign tgt_p = src_pulse(route.cpu, rc_p, xtal_p, ext_p, hp_p);

  // glitch-free switch: finish the old period, then wait for the new edge;
  // a stopped old source would stall the cpu, hence the two-write order
  // switch sequencer
  always_ff @(posedge clock)
  begin
    if (sleep_rst)
    begin
      sw_q <= SW_RUN;
      cur_q <= SRC_RC;
    end
    else
    begin
      case (sw_q)
        SW_RUN:
          if (route.cpu != cur_q)
            sw_q <= (cur_q == SRC_NONE) ? SW_ARM : SW_DRAIN;
        SW_DRAIN:
          if (cur_p)
            sw_q <= SW_ARM;
        SW_ARM:
          if (route.cpu == SRC_NONE)
          begin
            cur_q <= SRC_NONE;
            sw_q <= SW_RUN;
          end
          else if (tgt_p)
          begin
            cur_q <= route.cpu;
            sw_q <= SW_RUN;
          end
        default:
          sw_q <= SW_RUN;
      endcase
    end
  end

  // divide terminal count, codes above div16 clamp to div16
  assign div_last = DIV_CNT_W'((1 << ((cpu_div_code > DIV_CODE_MAX) ? DIV_CODE_MAX
                                                                     : cpu_div_code)) - 1);

  // cpu divider on rc or external
  always_ff @(posedge clock)
  begin
    if (sleep_rst || sw_q != SW_RUN)
      div_cnt_q <= '0;
    else if (cur_p)
      div_cnt_q <= (div_cnt_q >= div_last) ? '0 : div_cnt_q + DIV_CNT_W'(1);
  end

  assign div_p = (cur_q == SRC_RC || cur_q == SRC_EXT) ? (cur_p && div_cnt_q >= div_last)
                                                       : cur_p;

  // next values of the target enables
  assign cpu_d = (sw_q == SW_RUN) && (route.cpu == cur_q) && div_p;
  assign high_d = src_pulse(route.high_pre, rc_p, xtal_p, ext_p, hp_p);
  assign low_d = src_pulse(route.low_pre, rc_p, xtal_p, ext_p, hp_p);

  // registered clock enables; one cycle of latency on every target
  always_ff @(posedge clock)
  begin
    if (sleep_rst)
    begin
      cpu_clk_en <= 1'h0;
      high_pre_clk_en <= 1'h0;
      low_pre_clk_en <= 1'h0;
      slow_32k_clock <= 1'h0;
    end
    else
    begin
      cpu_clk_en <= cpu_d;
      high_pre_clk_en <= high_d;
      low_pre_clk_en <= low_d;
      slow_32k_clock <= hp_p;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  chk_reset_forces_rc: assert property (sleep_rst |=> ctrl_q.rc_osc_on &&
    !ctrl_q.cpu_slow_clock_select && cur_q == SRC_RC)
    else $error("rc not selected after reset or sleep");
  chk_sleep_sets_flag: assert property (sleep_rst |=> ctrl_q.crystal_warmup_flag
    && !ctrl_q.crystal_osc_on)
    else $error("warm-up flag or crystal enable wrong after reset");
  // low prescaler output checked, not the internal mask term
  chk_warmup_masks_xtal: assert property (ctrl_q.crystal_warmup_flag &&
    route.low_pre == SRC_XTAL |=> !low_pre_clk_en)
    else $error("crystal pulse passed during warm-up");
  chk_warmup_end_clears: assert property (warm_done && !sleep_rst
    && !xtal_start && !ctl_wr |=> !ctrl_q.crystal_warmup_flag && $stable(ctrl_q.crystal_osc_on))
    else $error("warm-up flag not cleared at end of count");
  chk_xtal_stop_ext: assert property (ctrl_q.ext_clock_select || sleep_mode
    |-> !xtal_osc_run)
    else $error("crystal runs with external clock or in sleep");
  // back-to-back writes are legal, so only the next cycle is pinned
  chk_xtal_disable: assert property (ctl_wr && !ctl_wdata[BIT_XTAL_ON]
    |=> !xtal_osc_run)
    else $error("crystal still running after disable");
  // synced rises are two cycles apart at best, halved pulses four
  chk_ext_half_rate: assert property (ext_p |=> !ext_p [*3])
    else $error("external pulse not divided by two");
  chk_switch_quiet: assert property (sw_q != SW_RUN |=> !cpu_clk_en)
    else $error("cpu pulse during source switch");
  chk_high_pre_off: assert property (!ctrl_q.rc_osc_on &&
    !ctrl_q.ext_clock_select |=> !high_pre_clk_en)
    else $error("high prescaler clocked with no source");
  // two rc pulses per cpu pulse leave at least three quiet cycles
  chk_div_spacing: assert property (cpu_clk_en && cur_q == SRC_RC &&
    cpu_div_code == 3'h1 && $stable(cpu_div_code) |=> !cpu_clk_en [*3])
    else $error("rc divide by two gave adjacent pulses");
  cov_warmup_done: cover property (ctrl_q.crystal_warmup_flag ##1 !ctrl_q.crystal_warmup_flag);
  cov_switch_to_xtal: cover property (sw_q == SW_ARM ##1 cur_q == SRC_XTAL);
  cov_ext_mode: cover property (cur_q == SRC_EXT && cpu_clk_en);
  cov_slow_hp: cover property (cur_q == SRC_HP && cpu_clk_en);

endmodule

// *** osc_pins_model.sv ***
// oscillator pins at the far side of the clock selector: rc, crystal,
// external clock and the 32 kHz tap; assumes the 40 MHz bench clock
`timescale 1ns/10ps

module osc_pins_model (
  input wire logic clock,
  input wire logic [3:0] run,
  output logic [3:0] pins
);
  // half periods in system cycles, one nibble per pin
  // rc faster than crystal
  localparam logic [15:0] HALF = 16'hC253;
  logic [3:0] cnt [4];

  initial
  begin
    pins = 4'h0;
    for (int i = 0; i < 4; i++)
      cnt[i] = 4'h0;
  end

  // a stopped oscillator holds low, so a restart begins from a clean rise
  always @(posedge clock)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (run[i] !== 1'b1)
      begin
        cnt[i] <= 4'h0;
        pins[i] <= 1'b0;
      end
      else if (cnt[i] == HALF[i*4 +: 4] - 4'h1)
      begin
        cnt[i] <= 4'h0;
        pins[i] <= ~pins[i];
      end
      else
        cnt[i] <= cnt[i] + 4'h1;
    end
  end
endmodule

// *** system_clock_source_select_tb.sv ***
// self-checking bench for the cpu clock source selector
// assumes the oscillator pin model beside it; warm-up shortened to 8
`timescale 1ns/10ps

module system_clock_source_select_tb
  import clk_src_pkg::*;
;
  localparam int WU = 8;
  typedef struct packed {
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rc;
    logic xtal;
  } row_t;
  logic clock, srst, sleep_mode, rst_n, ctl_wr, src_on;
  logic [7:0] ctl_wdata, ctl_rdata, v, prev;
  logic [2:0] cpu_div_code;
  logic rc_run, xtal_run, cpu_en, high_en, low_en, slow_en;
  logic [3:0] pins;
  int cnt [8];
  int failures, comparisons, n;
  row_t rows [5];

  system_clock_source_select #(.WARMUP_CYCLES(WU)) dut (
    .clock(clock), .srst(srst), .sleep_mode(sleep_mode), .external_reset_pin_n(rst_n),
    .rc_clk_pin(pins[0]), .xtal_clk_pin(pins[1]), .ext_clk_pin(pins[2]),
    .hp_tap_32k(pins[3]), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .cpu_div_code(cpu_div_code), .ctl_rdata(ctl_rdata), .rc_osc_run(rc_run),
    .xtal_osc_run(xtal_run), .cpu_clk_en(cpu_en), .high_pre_clk_en(high_en),
    .low_pre_clk_en(low_en), .slow_32k_clock(slow_en)
  );

  osc_pins_model osc (
    .clock(clock),
    .run({src_on, src_on, xtal_run, rc_run}),
    .pins(pins)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // tally pin rises and enable pulses over a window
  assign v = {slow_en, low_en, high_en, cpu_en, pins};
  always @(posedge clock)
  begin
    for (int i = 0; i < 8; i++)
      if (i < 4 ? (v[i] & !prev[i]) : v[i])
        cnt[i] <= cnt[i] + 1;
    prev <= v;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // counts only match to within a pulse or two of window phase
  task automatic near(input int a, input int b, input int tol);
    chk(32'(a), (a - b <= tol && b - a <= tol) ? 32'(a) : 32'(b));
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask

  task automatic wr(input logic [7:0] d);
    ctl_wr = 1'b1;
    ctl_wdata = d;
    cyc(1);
    ctl_wr = 1'b0;
    cyc(1);
  endtask

  task automatic window(input int k);
    for (int i = 0; i < 8; i++)
      cnt[i] = 0;
    cyc(k);
  endtask

  task automatic test_done();
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 5100 cycles
  initial
  begin
    #500000;
    failures++;
    test_done();
  end

  initial
  begin
    failures = 0;
    comparisons = 0;
    prev = 8'h00;
    srst = 1'b1;
    sleep_mode = 1'b0;
    rst_n = 1'b1;
    ctl_wr = 1'b0;
    ctl_wdata = 8'h00;
    cpu_div_code = 3'h0;
    src_on = 1'b1;
    rows[0] = {8'h01, 8'h09, 1'b1, 1'b0};
    rows[1] = {8'hFF, 8'hAB, 1'b1, 1'b0};
    rows[2] = {8'h00, 8'h08, 1'b0, 1'b0};
    rows[3] = {8'h83, 8'h8B, 1'b1, 1'b1};
    rows[4] = {8'h01, 8'h09, 1'b1, 1'b0};
    cyc(8);
    srst = 1'b0;
    chk({ctl_rdata, rc_run, xtal_run}, {8'h09, 2'h2});
    foreach (rows[i])
    begin
      wr(rows[i].wdata);
      chk({ctl_rdata, rc_run, xtal_run}, rows[i][9:0]);
    end
    // crystal start: rates are read only once the flag drops
    wr(8'h03);
    window(0);
    n = 0;
    while (ctl_rdata[3] !== 1'b0 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk(cnt[1], WU);
    chk(cnt[6], 0);
    window(200);
    chk(ctl_rdata, 8'h03);
    near(cnt[6], cnt[1], 1);
    near(cnt[5], cnt[0], 1);
    near(cnt[4], cnt[0], 1);
    wr(8'h83);
    cyc(40);
    window(200);
    near(cnt[4], cnt[1], 1);
    // crystal alone: cpu and low prescaler on crystal, high prescaler idle
    wr(8'h82);
    chk(ctl_rdata, 8'h82);
    window(200);
    chk(cnt[5], 0);
    near(cnt[4], cnt[1], 1);
    near(cnt[6], cnt[1], 1);
    // move the cpu back to rc, then stop the crystal
    wr(8'h03);
    cyc(40);
    wr(8'h01);
    for (int c = 0; c < 5; c++)
    begin
      cpu_div_code = 3'(c);
      cyc(40);
      window(480);
      near(cnt[4] * (1 << c), cnt[0], 2 << c);
    end
    near(cnt[5], cnt[0], 1);
    near(cnt[6], cnt[3], 1);
    // rc alone with the speed bit set: cpu moves to the 32 kHz tap
    wr(8'h81);
    cyc(60);
    window(480);
    near(cnt[4], cnt[3], 1);
    cpu_div_code = 3'h0;
    wr(8'h23);
    chk({ctl_rdata, xtal_run}, {8'h2B, 1'b0});
    // leaving the slow tap waits for the next tap pulse first
    cyc(60);
    window(480);
    near(cnt[5] * 2, cnt[2], 2);
    near(cnt[4] * 2, cnt[2], 2);
    near(cnt[6], cnt[3], 1);
    wr(8'hA3);
    cyc(60);
    window(480);
    near(cnt[4], cnt[3], 1);
    near(cnt[7], cnt[3], 1);
    // sleep keeps only the external select
    sleep_mode = 1'b1;
    cyc(2);
    chk({ctl_rdata, rc_run, xtal_run}, {8'h29, 2'h0});
    window(100);
    chk(cnt[4], 0);
    sleep_mode = 1'b0;
    cyc(2);
    chk({ctl_rdata, rc_run}, {8'h29, 1'b1});
    // a write under pin reset is refused
    rst_n = 1'b0;
    cyc(3);
    wr(8'h83);
    chk(ctl_rdata, 8'h09);
    rst_n = 1'b1;
    cyc(4);
    chk(ctl_rdata, 8'h09);
    test_done();
  end
endmodule
